// ---- inc/periph_cfg_pkg.sv ----
// Package for the peripheral enable and pin select register block.
// Assumes a single 32-bit configuration bus in the system clock domain.
package periph_cfg_pkg;
   localparam logic [31:0] CFG_REG_ADDR     = 32'h01B3F000; // Peripheral enable/select
   localparam logic [31:0] LOCK_REG_ADDR    = 32'h01B3F018; // Lock key / lock status
   localparam logic [31:0] UNLOCK_KEY       = 32'h10C0010C;
   localparam logic [31:0] CFG_WRITE_MASK   = 32'h0000006F; // Bits 6,5,3,2,1,0
   localparam logic [31:0] CFG_RESET_VALUE  = 32'h00000006;
   localparam int          BIT_AUDIO_SEL    = 0;
   localparam int          BIT_BSP0_EN      = 1;
   localparam int          BIT_ABSENT_EN    = 2;
   localparam int          BIT_TWI_EN       = 3;
   localparam int          BIT_VIDEO_ONE_EN = 5;
   localparam int          BIT_VIDEO_TWO_EN = 6;

   // Bus request as seen by the register block
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cfg_req_t;

   // Enables and pin ownership that leave the block
   typedef struct packed {
      logic video_port_two_enable;
      logic video_port_one_enable;
      logic two_wire_unit_enable;
      logic absent_serial_port_enable;
      logic buffered_serial_zero_enable;
      logic audio_port_pin_select;
      logic video_one_upper_own;
      logic video_one_lower_own;
   } periph_ctl_t;
endpackage

// ---- core/peripheral_enable_pin_select.sv ----
// Peripheral enable / power-down and shared pin select register with unlock key.
// Assumes the CPU drives the configuration bus synchronously to clk, one access per cycle.
// Reset is asynchronous; the lock comes back shut, so nothing changes before a key.
//
// Operation
// R01: Bits 31:7 and 4 read zero and ignore writes.
// R02: Bit 6 enables video port two; zero at reset powers it down.
// R03: Bit 5 enables video port one; zero at reset powers it down.
// R04: Bit 3 enables the two-wire unit; zero at reset powers it down.
// R05: Bit 2, absent serial port enable, is read-write and resets to one.
// R06: Software must clear the absent serial port enable bit.
// R07: Bit 1 enables buffered serial port zero; one at reset.
// R08: Bit 0 gives shared pins to audio port when one, video upper when zero.
// R09: Video port one lower pins depend on its enable and absent port bit.
// R10: The register decodes at its base address, one aligned word.
// R11: Enable and pin outputs follow stored bits directly.
// R12: Software writes the unlock key to the lock register first.
// R13: Locked register discards writes; reads are unaffected.
// R14: Any write to the register locks it again.
// R15: Access is only through the configuration bus.
`timescale 1ns/1ps
module peripheral_enable_pin_select
   import periph_cfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire cfg_req_t    req,
   output logic [31:0]      rdata,
   output logic             rvalid,
   output periph_ctl_t      ctl
);

   logic [31:0] cfg_q;
   logic [31:0] cfg_d;
   logic        locked_q;
   logic        locked_d;
   logic [31:0] rdata_d;

   // Address decode, shared by read and write paths
   function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
      return a[31:2] == base[31:2];
   endfunction

   wire cfg_sel   = hit(req.addr, CFG_REG_ADDR);     // [R10] [R15]
   wire lock_sel  = hit(req.addr, LOCK_REG_ADDR);
   wire cfg_wr    = req.wr && cfg_sel;
   wire cfg_take  = cfg_wr && !locked_q;             // [R13]
   wire key_ok    = req.wr && lock_sel && (req.wdata == UNLOCK_KEY); // [R12]

   // Only writable bits land; reserved bits stay zero so reads return zero
   assign cfg_d = cfg_take ? (req.wdata & CFG_WRITE_MASK) : cfg_q; // [R01] [R13]

   // A register write relocks even when it was discarded, so stray writes never leave it open
   assign locked_d = cfg_wr ? 1'b1 : (key_ok ? 1'b0 : locked_q); // [R14]

   // Read mux; unmapped addresses return zero
   assign rdata_d = cfg_sel  ? cfg_q :
                    lock_sel ? {31'h0, locked_q} : 32'h0;

   // Register state; the serial ports come up on and every other unit powered down
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q    <= CFG_RESET_VALUE;  // [R02] [R03] [R04] [R05] [R07] [R08]
         locked_q <= 1'b1;
      end else begin
         cfg_q    <= cfg_d;
         locked_q <= locked_d;
      end
   end

   // Read data registered, one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata  <= 32'h0;
         rvalid <= 1'b0;
      end else begin
         rdata  <= req.rd ? rdata_d : 32'h0;
         rvalid <= req.rd;
      end
   end

   // Outputs are wires off the stored bits: a new setting applies right after the write
   assign ctl.video_port_two_enable       = cfg_q[BIT_VIDEO_TWO_EN]; // [R02] [R11]
   assign ctl.video_port_one_enable       = cfg_q[BIT_VIDEO_ONE_EN]; // [R03] [R11]
   assign ctl.two_wire_unit_enable        = cfg_q[BIT_TWI_EN];       // [R04] [R11]
   assign ctl.absent_serial_port_enable   = cfg_q[BIT_ABSENT_EN];    // [R05] [R11]
   assign ctl.buffered_serial_zero_enable = cfg_q[BIT_BSP0_EN];      // [R07] [R11]
   assign ctl.audio_port_pin_select       = cfg_q[BIT_AUDIO_SEL];    // [R08] [R11]
   assign ctl.video_one_upper_own         = !cfg_q[BIT_AUDIO_SEL];   // [R08]
   // Lower pins ignore the audio select; the absent port takes them while its bit is set
   assign ctl.video_one_lower_own = cfg_q[BIT_VIDEO_ONE_EN] && !cfg_q[BIT_ABSENT_EN]; // [R09]

   // Checks on what software reads back
   property p_reserved_zero;
      @(posedge clk) disable iff (rst) rvalid |-> (rdata & ~CFG_WRITE_MASK) == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // [R01]

   property p_read;
      @(posedge clk) disable iff (rst) (req.rd && cfg_sel) |=> rvalid && rdata == $past(cfg_q);
   endproperty
   a_read: assert property (p_read) else $error("read data wrong"); // [R10]

   property p_lock_read;
      @(posedge clk) disable iff (rst)
         (req.rd && lock_sel) |=> rvalid && rdata == {31'h0, $past(locked_q)};
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("lock flag read wrong"); // [R13]

   property p_unmapped_read;
      @(posedge clk) disable iff (rst)
         (req.rd && !cfg_sel && !lock_sel) |=> rvalid && rdata == 32'h0;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped nonzero"); // [R10]

   // The read strobe is answered once; stale data would look like a second answer
   property p_rvalid_pulse;
      @(posedge clk) disable iff (rst) !req.rd |=> !rvalid && rdata == 32'h0;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read strobe stuck"); // [R15]

   // Lock flow: a key opens the register for one write, then it shuts again
   property p_unlock;
      @(posedge clk) disable iff (rst)
         (req.wr && lock_sel && req.wdata == UNLOCK_KEY) |=> !locked_q;
   endproperty
   a_unlock: assert property (p_unlock) else $error("key did not unlock"); // [R12]

   property p_bad_key;
      @(posedge clk) disable iff (rst)
         (req.wr && lock_sel && req.wdata != UNLOCK_KEY) |=> $stable(locked_q);
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("wrong key changed lock"); // [R13]

   property p_relock;
      @(posedge clk) disable iff (rst) (req.wr && cfg_sel) |=> locked_q;
   endproperty
   a_relock: assert property (p_relock) else $error("not relocked"); // [R14]

   property p_locked_hold;
      @(posedge clk) disable iff (rst) (req.wr && cfg_sel && locked_q) |=> $stable(cfg_q);
   endproperty
   a_locked_hold: assert property (p_locked_hold) else $error("locked write changed reg"); // [R13]

   property p_read_quiet;
      @(posedge clk) disable iff (rst)
         (req.rd && !req.wr) |=> $stable(locked_q) && $stable(cfg_q);
   endproperty
   a_read_quiet: assert property (p_read_quiet) else $error("read changed state"); // [R13]

   // Only an accepted write may move the stored word; a stray change would power units up
   property p_idle_hold;
      @(posedge clk) disable iff (rst)
         !(req.wr && cfg_sel && !locked_q) |=> $stable(cfg_q);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("stored word drifted"); // [R13]

   // An accepted write lands as masked data and reaches the outputs one edge later
   property p_unlocked_write;
      @(posedge clk) disable iff (rst)
         (req.wr && cfg_sel && !locked_q) |=> cfg_q == ($past(req.wdata) & CFG_WRITE_MASK);
   endproperty
   a_unlocked_write: assert property (p_unlocked_write) else $error("write not stored"); // [R11]

   property p_video_two;
      @(posedge clk) disable iff (rst) (req.wr && cfg_sel && !locked_q)
         |=> ctl.video_port_two_enable == $past(req.wdata[BIT_VIDEO_TWO_EN]);
   endproperty
   a_video_two: assert property (p_video_two) else $error("port two enable not applied"); // [R02]

   property p_video_one;
      @(posedge clk) disable iff (rst) (req.wr && cfg_sel && !locked_q)
         |=> ctl.video_port_one_enable == $past(req.wdata[BIT_VIDEO_ONE_EN]);
   endproperty
   a_video_one: assert property (p_video_one) else $error("port one enable not applied"); // [R03]

   property p_twi;
      @(posedge clk) disable iff (rst) (req.wr && cfg_sel && !locked_q)
         |=> ctl.two_wire_unit_enable == $past(req.wdata[BIT_TWI_EN]);
   endproperty
   a_twi: assert property (p_twi) else $error("two-wire enable not applied"); // [R04]

   property p_bsp;
      @(posedge clk) disable iff (rst) (req.wr && cfg_sel && !locked_q)
         |=> ctl.buffered_serial_zero_enable == $past(req.wdata[BIT_BSP0_EN])
         && ctl.absent_serial_port_enable == $past(req.wdata[BIT_ABSENT_EN]);
   endproperty
   a_bsp: assert property (p_bsp) else $error("serial enable not applied"); // [R05] [R07]

   property p_pins;
      @(posedge clk) disable iff (rst) (req.wr && cfg_sel && !locked_q)
         |=> ctl.video_one_upper_own == !$past(req.wdata[BIT_AUDIO_SEL])
         && ctl.video_one_lower_own
            == ($past(req.wdata[BIT_VIDEO_ONE_EN]) && !$past(req.wdata[BIT_ABSENT_EN]));
   endproperty
   a_pins: assert property (p_pins) else $error("pin ownership wrong"); // [R08] [R09] [R11]

   // Defaults at the first edge after release: serial ports on, video upper pins owned, everything else off
   property p_reset_off;
      @(posedge clk) $fell(rst) |-> locked_q && !ctl.video_port_two_enable
         && !ctl.video_port_one_enable && !ctl.two_wire_unit_enable;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("on at reset"); // [R02] [R03] [R04]

   property p_reset_on;
      @(posedge clk) $fell(rst) |-> ctl.absent_serial_port_enable
         && ctl.buffered_serial_zero_enable && !ctl.audio_port_pin_select
         && ctl.video_one_upper_own && !ctl.video_one_lower_own;
   endproperty
   a_reset_on: assert property (p_reset_on) else $error("bad reset pins"); // [R05] [R07] [R08]

   // Coverage of the main scenarios
   c_unlock_write: cover property (@(posedge clk) disable iff (rst)
      key_ok ##1 (req.wr && cfg_sel));
   c_locked_write: cover property (@(posedge clk) disable iff (rst) req.wr && cfg_sel && locked_q);
   c_audio_sel: cover property (@(posedge clk) disable iff (rst) ctl.audio_port_pin_select);
   c_lower_pins: cover property (@(posedge clk) disable iff (rst) ctl.video_one_lower_own);
   c_bad_key: cover property (@(posedge clk) disable iff (rst)
      req.wr && lock_sel && req.wdata != UNLOCK_KEY);
endmodule

// ---- testbench/cpu_bus_model.sv ----
// CPU side of the configuration bus: word accesses and the unlock flow.
// Assumes the block answers a read exactly one cycle after the request.
`timescale 1ns/1ps
module cpu_bus_model
   import periph_cfg_pkg::*;
(
   input  wire logic        clk,
   output cfg_req_t         req,
   input  wire logic [31:0] rdata,
   input  wire logic        rvalid
);
   // Idle bus from time zero
   initial req = '0;
   // Request at a falling edge, taken at the next rising edge
   task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d,
                         output logic [32:0] q);
      @(negedge clk);
      req = '{rd: ~w, wr: w, addr: a, wdata: d};
      @(negedge clk);
      q = {rvalid, rdata};
      // Released lines carry inverted values so stale data cannot match
      req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // Unlock, then a single config write
   task automatic cfg_write(input logic [31:0] v, input logic keep_absent);
      logic [32:0] q;
      access(1'b1, LOCK_REG_ADDR, UNLOCK_KEY, q);
      if (!keep_absent)
         v[2] = 1'b0;
      access(1'b1, CFG_REG_ADDR, v, q);
   endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the peripheral enable and pin select register.
// Assumes the bus model drives all requests at falling clock edges.
`timescale 1ns/1ps
module tb
   import periph_cfg_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   cfg_req_t    req;
   logic [31:0] rdata;
   logic        rvalid;
   periph_ctl_t ctl;
   logic [32:0] q;
   int          n_fail = 0;
   int          checks_done = 0;
   // 125 MHz clock
   always #4 clk = ~clk;
   peripheral_enable_pin_select dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
                                     .rvalid(rvalid), .ctl(ctl));
   cpu_bus_model cpu (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
   task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Expected outputs worked out from register bits
   function automatic logic [32:0] ctl_of(input logic [31:0] v);
      return {25'h0, v[6], v[5], v[3], v[2], v[1], v[0], ~v[0], v[5] & ~v[2]};
   endfunction
   task automatic t_reset();
      cpu.access(1'b0, 32'h01B3F003, 32'h0, q);
      chk("cfg reset", 33'h1_0000_0006, q);
      chk("ctl reset", ctl_of(32'h6), {25'h0, ctl});
      cpu.access(1'b0, 32'h01B3F010, 32'h0, q);
      chk("unmapped", 33'h1_0000_0000, q);
      $display("test reset done");
   endtask
   task automatic t_lock();
      cpu.access(1'b1, CFG_REG_ADDR, 32'hFFFFFFFF, q);
      cpu.access(1'b1, LOCK_REG_ADDR, 32'h10C0010D, q);
      cpu.access(1'b1, CFG_REG_ADDR, 32'hFFFFFFFF, q);
      cpu.access(1'b0, CFG_REG_ADDR, 32'h0, q);
      chk("locked cfg", 33'h1_0000_0006, q);
      cpu.access(1'b0, LOCK_REG_ADDR, 32'h0, q);
      chk("lock flag", 33'h1_0000_0001, q);
      cpu.access(1'b1, LOCK_REG_ADDR, 32'h10C0010C, q);
      cpu.access(1'b0, LOCK_REG_ADDR, 32'h0, q);
      chk("open flag", 33'h1_0000_0000, q);
      cpu.access(1'b1, CFG_REG_ADDR, 32'hFFFFFFFF, q);
      chk("ctl all", ctl_of(32'h6F), {25'h0, ctl});
      // Relocked, so this clear must be dropped
      cpu.access(1'b1, CFG_REG_ADDR, 32'h0, q);
      cpu.access(1'b0, CFG_REG_ADDR, 32'h0, q);
      chk("relock", 33'h1_0000_006F, q);
      $display("test lock done");
   endtask
   task automatic t_pins();
      logic [31:0] v [4] = '{32'h20, 32'h25, 32'h61, 32'h4E};
      logic [31:0] e;
      foreach (v[i]) begin
         cpu.cfg_write(v[i], i == 1);
         e = (i == 1) ? v[i] : v[i] & ~32'h4;
         chk("pin ctl", ctl_of(e), {25'h0, ctl});
         cpu.access(1'b0, CFG_REG_ADDR, 32'h0, q);
         chk("pin cfg", {1'b1, e}, q);
      end
      $display("test pins done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Reset for 3 cycles, then the tests
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_lock();
      t_pins();
      test_done();
   end
   // Watchdog: the tests need well under 100 cycles
   initial begin
      #(8 * 1000);
      n_fail++;
      test_done();
   end
endmodule
